// ===== tcs_pkg.sv
// Constants and types shared by the trip circuit supervisor.
`default_nettype none
package tcs_pkg;
    // Sample period between queries, in milliseconds.
    localparam int QUERY_PERIOD_MS = 500;
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int QUERY_PERIOD_CYC = QUERY_PERIOD_MS * (CLK_FREQ_HZ / 1000);
    // Consecutive equal queries needed to set or reset the alarm.
    localparam int FAULT_QUERY_COUNT = 3;
    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [31:0] TICK_ZERO = 32'h0000_0000;
    localparam logic [31:0] TICK_ONE = 32'h0000_0001;
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_BLOCKED = 3'b010,
        ST_ACTIVE = 3'b100
    } sup_state_t;
endpackage
`default_nettype wire

// ===== trip_circuit_supervisor.sv
// Trip circuit supervisor with one- or two-input sensing and debounced alarm.
//
// How it works
// - Both inputs low normal only during trip
// - Two-input fault criterion: both inputs low
// - Query the sensing inputs every 500 ms
// - Alarm after three consecutive faulty queries
// - Alarm clears after three consecutive healthy queries
// - One-input mode: high input is healthy
// - One-input: persistent low raises failure
// - One-input: momentary low raises nothing
// - Parallel trip contacts: alarm is delayed
// - One-input: alarm clears when input healthy
// - Supervision suspended during system fault
// - Mode select; mismatched allocation raises message
// - Enable defaults off; off status, no alarm
// - Block input suspends and shows blocked
// - Active and failure status outputs
`timescale 1ns/1ns
`default_nettype none
module trip_circuit_supervisor
    import tcs_pkg::*;
#(
    parameter int QUERY_CYCLES = QUERY_PERIOD_CYC,
    parameter int FAULT_COUNT = FAULT_QUERY_COUNT
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic supervision_enable,
    input wire logic two_input_mode,
    input wire logic trip_sense_allocated,
    input wire logic aux_sense_allocated,
    input wire logic supervision_block_in,
    input wire logic system_fault_in,
    input wire logic trip_contact_sense_in,
    input wire logic breaker_aux_sense_in,
    output logic supervision_off_status,
    output logic supervision_blocked_status,
    output logic supervision_active_status,
    output logic trip_circuit_fail,
    output logic input_alloc_mismatch_msg
);
    // The run counter is two bits wide; this check limits the filter to one to three queries.
    if (QUERY_CYCLES < 1 || FAULT_COUNT < 1 || FAULT_COUNT > 3)
    begin : g_bad_params
        $error("trip_circuit_supervisor: unsupported parameter values");
    end

    localparam logic [31:0] TICK_LAST = 32'(QUERY_CYCLES - 1);
    localparam logic [1:0] CNT_LAST = 2'(FAULT_COUNT - 1);

    sup_state_t state_ff;
    sup_state_t nxt_state;
    logic [31:0] tick_cnt_ff;
    logic query_ff;
    logic [1:0] run_cnt_ff;
    logic fail_ff;
    logic mismatch_ff;
    logic mismatch_now;
    logic fault_now;
    logic running;

    // Allocation must match mode: both inputs in two-input mode, only the trip input otherwise.
    // The state decode uses the live value, so a mode change lets at most one unchecked cycle run.
    always_comb
    begin
        if (two_input_mode)
            mismatch_now = !(trip_sense_allocated && aux_sense_allocated);
        else
            mismatch_now = !trip_sense_allocated || aux_sense_allocated;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            mismatch_ff <= 1'b0;
        else if (clk_en)
            mismatch_ff <= mismatch_now;
    end

    // A mismatched allocation also keeps supervision from running, since the inputs mean nothing.
    always_comb
    begin
        if (!supervision_enable)
            nxt_state = ST_OFF;
        else if (supervision_block_in || system_fault_in || mismatch_now)
            nxt_state = ST_BLOCKED;
        else
            nxt_state = ST_ACTIVE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_ff <= ST_OFF;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    assign running = (state_ff == ST_ACTIVE);

    // Free-running query tick; one pulse per period.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tick_cnt_ff <= TICK_ZERO;
            query_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            query_ff <= (tick_cnt_ff == TICK_LAST);
            tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? TICK_ZERO : tick_cnt_ff + TICK_ONE;
        end
    end

    // Two-input: both low is the fault criterion, the short both-low trip transition is
    // filtered by the count. One-input: low is the fault criterion.
    always_comb
    begin
        case (two_input_mode)
            1'b1: fault_now = !trip_contact_sense_in && !breaker_aux_sense_in;
            1'b0: fault_now = !trip_contact_sense_in;
            default: fault_now = 1'b0;
        endcase
    end

    // Counts queries that disagree with the current alarm; any agreeing query restarts it.
    // The same count guards setting and clearing, so brief lows never reach the alarm.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            run_cnt_ff <= CNT_ZERO;
            fail_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!running)
            begin
                run_cnt_ff <= CNT_ZERO;
                fail_ff <= 1'b0;
            end
            else if (query_ff)
            begin
                if (fault_now == fail_ff)
                    run_cnt_ff <= CNT_ZERO;
                else if (run_cnt_ff == CNT_LAST)
                begin
                    run_cnt_ff <= CNT_ZERO;
                    fail_ff <= fault_now;
                end
                else
                    run_cnt_ff <= run_cnt_ff + CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            supervision_off_status <= 1'b1;
            supervision_blocked_status <= 1'b0;
            supervision_active_status <= 1'b0;
            trip_circuit_fail <= 1'b0;
            input_alloc_mismatch_msg <= 1'b0;
        end
        else if (clk_en)
        begin
            supervision_off_status <= (state_ff == ST_OFF);
            supervision_blocked_status <= (state_ff == ST_BLOCKED);
            supervision_active_status <= running;
            trip_circuit_fail <= fail_ff && running;
            input_alloc_mismatch_msg <= mismatch_ff;
        end
    end

    // Assertions and covers.
    property p_off_no_alarm;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && state_ff == ST_OFF |=> !trip_circuit_fail;
    endproperty
    a_off_no_alarm: assert property (p_off_no_alarm) else $error("alarm while off");

    property p_block_status;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && supervision_enable && supervision_block_in ##1 clk_en
            |=> supervision_blocked_status;
    endproperty
    a_block_status: assert property (p_block_status) else $error("blocked not shown");

    property p_fault_suspends;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && system_fault_in ##1 clk_en |=> !supervision_active_status;
    endproperty
    a_fault_suspends: assert property (p_fault_suspends) else $error("runs in fault");

    property p_clear_counter;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && !running |=> run_cnt_ff == CNT_ZERO && !fail_ff;
    endproperty
    a_clear_counter: assert property (p_clear_counter) else $error("count kept");

    property p_rise_needs_queries;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(fail_ff) |-> $past(run_cnt_ff) == CNT_LAST && $past(query_ff) && $past(fault_now);
    endproperty
    a_rise_needs_queries: assert property (p_rise_needs_queries) else $error("early alarm");

    property p_fall_needs_queries;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(fail_ff) && $past(running) |-> $past(run_cnt_ff) == CNT_LAST && !$past(fault_now);
    endproperty
    a_fall_needs_queries: assert property (p_fall_needs_queries) else $error("early clear");

    property p_tick_period;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && query_ff |=> !query_ff;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("query too fast");

    property p_mismatch;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && two_input_mode && !aux_sense_allocated ##1 clk_en |=> input_alloc_mismatch_msg;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("no mismatch message");

    property p_two_healthy;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && running && query_ff && two_input_mode && breaker_aux_sense_in && !fail_ff
            |=> run_cnt_ff == CNT_ZERO;
    endproperty
    a_two_healthy: assert property (p_two_healthy) else $error("healthy counted");

    property p_fail_active;
        @(posedge clk_sys) disable iff (!rst_n)
        trip_circuit_fail |-> supervision_active_status;
    endproperty
    a_fail_active: assert property (p_fail_active) else $error("idle alarm");

    property p_one_status;
        @(posedge clk_sys) disable iff (!rst_n)
        $onehot({supervision_off_status, supervision_blocked_status, supervision_active_status});
    endproperty
    a_one_status: assert property (p_one_status) else $error("bad status");

    property p_off_status;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && !supervision_enable ##1 clk_en |=> supervision_off_status;
    endproperty
    a_off_status: assert property (p_off_status) else $error("off not shown");

    property p_one_healthy;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && running && query_ff && !two_input_mode && trip_contact_sense_in && !fail_ff
            |=> run_cnt_ff == CNT_ZERO;
    endproperty
    a_one_healthy: assert property (p_one_healthy) else $error("healthy counted");

    property p_one_low;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && running && query_ff && !two_input_mode && !trip_contact_sense_in && !fail_ff
            |=> fail_ff || run_cnt_ff == $past(run_cnt_ff) + CNT_ONE;
    endproperty
    a_one_low: assert property (p_one_low) else $error("low not counted");

    property p_two_low;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && running && query_ff && two_input_mode && !trip_contact_sense_in
            && !breaker_aux_sense_in && !fail_ff
            |=> fail_ff || run_cnt_ff == $past(run_cnt_ff) + CNT_ONE;
    endproperty
    a_two_low: assert property (p_two_low) else $error("both low not counted");

    // Between queries the alarm must hold, so a short low that no query sees is invisible.
    property p_query_only;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && running && !query_ff |=> $stable(fail_ff);
    endproperty
    a_query_only: assert property (p_query_only) else $error("alarm off query");

    property p_one_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(fail_ff) && $past(running) && !$past(two_input_mode)
            |-> $past(trip_contact_sense_in);
    endproperty
    a_one_clear: assert property (p_one_clear) else $error("clear while low");

    property p_one_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(fail_ff) && !$past(two_input_mode)
            |-> !$past(trip_contact_sense_in) && $past(run_cnt_ff) == CNT_LAST;
    endproperty
    a_one_rise: assert property (p_one_rise) else $error("undelayed alarm");

    property p_mism_one;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && !two_input_mode && aux_sense_allocated ##1 clk_en |=> input_alloc_mismatch_msg;
    endproperty
    a_mism_one: assert property (p_mism_one) else $error("no mismatch message");

    property p_mism_block;
        @(posedge clk_sys) disable iff (!rst_n)
        input_alloc_mismatch_msg |-> !supervision_active_status;
    endproperty
    a_mism_block: assert property (p_mism_block) else $error("runs mismatched");

    c_alarm: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(trip_circuit_fail));
    c_alarm_clear: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(fail_ff) && running);
    c_blocked: cover property (@(posedge clk_sys) disable iff (!rst_n) supervision_blocked_status);
    c_mismatch: cover property (@(posedge clk_sys) disable iff (!rst_n) input_alloc_mismatch_msg);
    c_two_alarm: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(fail_ff) && two_input_mode);
endmodule
`default_nettype wire

// ===== trip_circuit_model.sv
// Behavioural trip circuit with breaker contacts, seen through two sense inputs.
`timescale 1ns/1ns
`default_nettype none
module trip_circuit_model (
    input wire logic trip_closed,
    input wire logic breaker_on,
    input wire logic circuit_broken,
    output logic sense_first,
    output logic sense_second
);
    // A broken circuit leaves both inputs unpowered.
    assign sense_first = !circuit_broken && !trip_closed;
    assign sense_second = !circuit_broken && !breaker_on;
endmodule
`default_nettype wire

// ===== test_trip_circuit_supervisor.sv
// Self-checking bench for the trip circuit supervisor.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) compare(a, b)
module test_trip_circuit_supervisor;
    import tcs_pkg::*;
    localparam int Q = 8;
    logic clk_sys, rst_n, ce, en, two, alloc_t, alloc_a, blk, sflt;
    logic trip_closed, cb_on, broken, s1, s2;
    logic off_st, blk_st, act_st, fail, mism;
    int error_cnt, checked, seed, n;
    trip_circuit_model far (.trip_closed(trip_closed), .breaker_on(cb_on),
        .circuit_broken(broken), .sense_first(s1), .sense_second(s2));
    trip_circuit_supervisor #(.QUERY_CYCLES(Q), .FAULT_COUNT(FAULT_QUERY_COUNT)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .supervision_enable(en),
        .two_input_mode(two), .trip_sense_allocated(alloc_t),
        .aux_sense_allocated(alloc_a), .supervision_block_in(blk),
        .system_fault_in(sflt), .trip_contact_sense_in(s1), .breaker_aux_sense_in(s2),
        .supervision_off_status(off_st), .supervision_blocked_status(blk_st),
        .supervision_active_status(act_st), .trip_circuit_fail(fail),
        .input_alloc_mismatch_msg(mism));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic crit(logic two_m, logic a, logic b);
        return two_m ? (!a && !b) : !a;
    endfunction
    task automatic compare(logic got, logic exp);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic go(int cyc);
        repeat (cyc) @(posedge clk_sys);
        #1;
    endtask
    // Two query periods can never complete the filter; three and a margin must.
    task automatic hold(logic prev, logic want);
        go(2 * Q);
        `CHK(fail, prev);
        go(Q + 4);
        `CHK(fail, want);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (Q * 200) @(posedge clk_sys);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        {rst_n, en, two, alloc_t, alloc_a, blk, sflt, trip_closed, broken} = 9'h000;
        cb_on = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        checked = 0;
        seed = 32'h541b_87d0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        go(3);
        `CHK(off_st, 1'b1);
        `CHK(act_st, 1'b0);
        `CHK(mism, 1'b1);
        @(posedge clk_sys);
        en <= 1'b1;
        alloc_t <= 1'b1;
        go(3);
        `CHK(act_st, 1'b1);
        `CHK(mism, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_sys);
            trip_closed <= 1'b1;
            n = 1 + ($unsigned($random(seed)) % (Q - 1));
            repeat (n) @(posedge clk_sys);
            trip_closed <= 1'b0;
            go(2);
            `CHK(fail, 1'b0);
            go(Q);
            `CHK(fail, 1'b0);
        end
        @(posedge clk_sys);
        broken <= 1'b1;
        hold(1'b0, crit(1'b0, 1'b0, 1'b0));
        `CHK(act_st, 1'b1);
        @(posedge clk_sys);
        broken <= 1'b0;
        hold(1'b1, crit(1'b0, 1'b1, 1'b1));
        @(posedge clk_sys);
        broken <= 1'b1;
        hold(1'b0, 1'b1);
        // A frozen block must keep its alarm although the circuit has healed meanwhile.
        @(posedge clk_sys);
        ce <= 1'b0;
        broken <= 1'b0;
        go(4 * Q);
        `CHK(fail, 1'b1);
        `CHK(act_st, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b1;
        broken <= 1'b1;
        @(posedge clk_sys);
        blk <= 1'b1;
        go(3);
        `CHK(blk_st, 1'b1);
        `CHK(act_st, 1'b0);
        `CHK(fail, 1'b0);
        @(posedge clk_sys);
        blk <= 1'b0;
        go(2 * Q);
        `CHK(fail, 1'b0);
        @(posedge clk_sys);
        sflt <= 1'b1;
        go(3);
        `CHK(blk_st, 1'b1);
        `CHK(fail, 1'b0);
        @(posedge clk_sys);
        sflt <= 1'b0;
        broken <= 1'b0;
        two <= 1'b1;
        go(3);
        `CHK(mism, 1'b1);
        `CHK(blk_st, 1'b1);
        @(posedge clk_sys);
        alloc_a <= 1'b1;
        go(3);
        `CHK(mism, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys);
            trip_closed <= k[0];
            cb_on <= k[1];
            hold(1'b0, crit(1'b1, !k[0], !k[1]));
        end
        @(posedge clk_sys);
        trip_closed <= 1'b0;
        hold(1'b1, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        go(2);
        `CHK(off_st, 1'b1);
        `CHK(act_st, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        go(3);
        `CHK(act_st, 1'b1);
        @(posedge clk_sys);
        en <= 1'b0;
        go(3);
        `CHK(off_st, 1'b1);
        `CHK(fail, 1'b0);
        @(posedge clk_sys);
        two <= 1'b0;
        go(3);
        `CHK(mism, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
